// [rtl/twsi_pkg.sv]
// Constants and state type of the two-wire serial unit.
// Assumes one synchronous reset and no register bus.
package twsi_pkg;
  // Bit counter positions within a frame
  localparam logic [3:0] TWSI_CNT_RST = 4'h0;
  localparam logic [3:0] TWSI_BYTE_LAST = 4'h7;
  localparam logic [3:0] TWSI_ACK_BIT = 4'h8;
  localparam logic [3:0] TWSI_I2C_LAST = 4'h8;
  localparam logic [3:0] TWSI_SYNC_LAST = 4'h7;
  // Reset values
  localparam logic [7:0] TWSI_DATA_RST = 8'h00;
  localparam logic [3:0] TWSI_SEL_RST = 4'h0;
  localparam logic [15:0] TWSI_DIV_RST = 16'h0000;
  // Half bit period of the link divider is this base shifted by the select
  localparam logic [15:0] TWSI_DIV_BASE = 16'h0001;
  typedef enum logic [2:0] {
    TW_IDLE,
    TW_START,
    TW_LOW,
    TW_HIGH,
    TW_NEXT,
    TW_HOLD,
    TW_STOP_LOW,
    TW_STOP_HIGH
  } twsi_state_type;
endpackage

// [rtl/twsi_top.sv]
`timescale 1ns/100ps
// Two-wire serial unit: I2C-format master/slave and clock-sync format.
// Assumes sys_clk control ports, open-drain pins resolved outside and a
// free-running link_clk that paces the master bit rate.

// Behaviour
// - Master or slave chosen by master_select
// - Master makes start and stop by itself
// - Acknowledge captured after each transmitted I2C-format byte
// - Master waits for real clock line high
// - Clock held low until transfer can proceed in I2C format
// - Pins only pull low, otherwise released
// - Slave takes clock from clock pin
// - Master drives clock from selected divider
// - Sync receive into full buffer flags overrun
// - Shift, transmit and receive registers independent
// - Software picks acknowledge level when receiving
// - Sync format picks MSB or LSB first
// - All requests share one interrupt output
module twsi_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic master_select,
  input wire logic sync_format,
  input wire logic transmit_mode,
  input wire logic ack_level,
  input wire logic lsb_first,
  input wire logic [3:0] clock_divider_select,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  input wire logic rx_read,
  input wire logic overrun_clear,
  output logic tx_empty,
  output logic receive_full_flag,
  output logic [7:0] receive_data_reg,
  output logic ack_received,
  output logic overrun_loss_flag,
  output logic bus_busy,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  twsi_pkg::twsi_state_type state;
  logic [2:0] link_rst_sync;
  logic link_rst;
  logic [3:0] sel_s1;
  logic [3:0] sel_s2;
  logic [3:0] sel_s3;
  logic [3:0] sel_link;
  logic [15:0] div_cnt;
  logic tick_toggle;
  logic [2:0] tog_sync;
  logic tog_seen;
  logic tick;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic scl_drive;
  logic sda_drive;
  logic hi_seen;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx_buf;
  logic tx_take_p;
  logic rx_store_p;
  logic rx_over_p;
  logic start_take_p;
  logic stop_take_p;
  logic start_pend;
  logic stop_pend;
  logic [3:0] last_bit;
  logic byte_end;
  logic can_go;
  logic take_tx;
  logic [7:0] load_val;
  logic [7:0] next_shift;
  logic sample_now;

  // Half bit period in link clocks for a divider select value
  function automatic logic [15:0] div_limit(input logic [3:0] sel);
    div_limit = twsi_pkg::TWSI_DIV_BASE << sel;
  endfunction

  // Receive shift in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic din);
    shift_in = lsb_first ? {din, sh[7:1]} : {sh[6:0], din};
  endfunction

  // Whether data must be pulled low for bit cnt of the frame
  function automatic logic pull_low(input logic [7:0] sh, input logic [3:0] cnt);
    if (!sync_format && cnt == twsi_pkg::TWSI_ACK_BIT) begin
      pull_low = transmit_mode ? 1'b0 : ~ack_level;
    end else if (transmit_mode) begin
      pull_low = lsb_first ? ~sh[0] : ~sh[7];
    end else begin
      pull_low = 1'b0;
    end
  endfunction

  // Link domain reset, caught from the system reset
  always_ff @(posedge link_clk) begin
    link_rst_sync <= {link_rst_sync[1:0], reset};
  end
  assign link_rst = link_rst_sync[2];

  // Divider select crosses as a quasi-static level; taken once stable
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      sel_s1 <= twsi_pkg::TWSI_SEL_RST;
      sel_s2 <= twsi_pkg::TWSI_SEL_RST;
      sel_s3 <= twsi_pkg::TWSI_SEL_RST;
      sel_link <= twsi_pkg::TWSI_SEL_RST;
    end else begin
      sel_s1 <= clock_divider_select;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      if (sel_s2 == sel_s3) begin
        sel_link <= sel_s3;
      end
    end
  end

  // Bit rate divider; a toggle carries each half period across
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      div_cnt <= twsi_pkg::TWSI_DIV_RST;
      tick_toggle <= 1'b0;
    end else if (div_cnt >= div_limit(sel_link) - twsi_pkg::TWSI_DIV_BASE) begin
      div_cnt <= twsi_pkg::TWSI_DIV_RST;
      tick_toggle <= ~tick_toggle;
    end else begin
      div_cnt <= div_cnt + twsi_pkg::TWSI_DIV_BASE;
    end
  end

  // Toggle into sys_clk; a change counts when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tog_sync <= 3'h0;
      tog_seen <= 1'b0;
      tick <= 1'b0;
    end else begin
      tog_sync <= {tog_sync[1:0], tick_toggle};
      tick <= 1'b0;
      if (tog_sync[1] == tog_sync[2] && tog_sync[2] != tog_seen) begin
        tog_seen <= tog_sync[2];
        tick <= 1'b1;
      end
    end
  end

  // Pin filters: the lines idle high, so they reset high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_s <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_s <= sda_sync[2];
      end
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Line events; start and stop need the clock high on both samples
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_seen = ~sda_s & sda_q & scl_s & scl_q;
  assign stop_seen = sda_s & ~sda_q & scl_s & scl_q;

  // Bus ownership seen on the wires, whoever made the conditions
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_busy <= 1'b0;
    end else if (start_seen) begin
      bus_busy <= 1'b1;
    end else if (stop_seen) begin
      bus_busy <= 1'b0;
    end
  end

  // Frame decode shared by master and slave
  assign last_bit = sync_format ? twsi_pkg::TWSI_SYNC_LAST : twsi_pkg::TWSI_I2C_LAST;
  assign byte_end = bit_cnt == last_bit;
  assign can_go = transmit_mode ? ~tx_empty : ~receive_full_flag;
  assign take_tx = transmit_mode & ~tx_empty;
  assign load_val = take_tx ? tx_buf : shift;
  assign next_shift = shift_in(shift, sda_s);
  // Master samples at the end of a high phase it has really seen
  assign sample_now = master_select
    ? (state == twsi_pkg::TW_HIGH && hi_seen && (tick || !scl_s))
    : (state == twsi_pkg::TW_LOW && scl_rise);

  // Transfer sequencer; sampling first, then the phase steps
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= twsi_pkg::TW_IDLE;
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
      hi_seen <= 1'b0;
      bit_cnt <= twsi_pkg::TWSI_CNT_RST;
      shift <= twsi_pkg::TWSI_DATA_RST;
      receive_data_reg <= twsi_pkg::TWSI_DATA_RST;
      ack_received <= 1'b1;
      tx_take_p <= 1'b0;
      rx_store_p <= 1'b0;
      rx_over_p <= 1'b0;
      start_take_p <= 1'b0;
      stop_take_p <= 1'b0;
    end else begin
      tx_take_p <= 1'b0;
      rx_store_p <= 1'b0;
      rx_over_p <= 1'b0;
      start_take_p <= 1'b0;
      stop_take_p <= 1'b0;
      if (sample_now) begin
        if (bit_cnt <= twsi_pkg::TWSI_BYTE_LAST) begin
          shift <= next_shift;
        end
        if (bit_cnt == twsi_pkg::TWSI_BYTE_LAST && !transmit_mode) begin
          // Full buffer keeps old data; an I2C master stalls so never gets here
          if (receive_full_flag) begin
            rx_over_p <= sync_format;
          end else begin
            rx_store_p <= 1'b1;
            receive_data_reg <= next_shift;
          end
        end
        if (bit_cnt == twsi_pkg::TWSI_ACK_BIT && !sync_format && transmit_mode) begin
          ack_received <= sda_s;
        end
      end
      case (state)
        twsi_pkg::TW_IDLE: begin
          if (master_select && !sync_format && start_pend && !bus_busy) begin
            sda_drive <= 1'b1;
            start_take_p <= 1'b1;
            state <= twsi_pkg::TW_START;
          end else if (master_select && sync_format && can_go) begin
            scl_drive <= 1'b1;
            shift <= load_val;
            tx_take_p <= take_tx;
            bit_cnt <= twsi_pkg::TWSI_CNT_RST;
            sda_drive <= pull_low(load_val, twsi_pkg::TWSI_CNT_RST);
            state <= twsi_pkg::TW_LOW;
          end else if (!master_select && (sync_format || start_seen)) begin
            shift <= load_val;
            tx_take_p <= take_tx;
            bit_cnt <= twsi_pkg::TWSI_CNT_RST;
            sda_drive <= pull_low(load_val, twsi_pkg::TWSI_CNT_RST);
            state <= twsi_pkg::TW_LOW;
          end
        end
        twsi_pkg::TW_START: begin
          // Data is already low; pulling the clock completes the start
          if (tick) begin
            scl_drive <= 1'b1;
            state <= twsi_pkg::TW_HOLD;
          end
        end
        twsi_pkg::TW_LOW: begin
          if (master_select && tick) begin
            scl_drive <= 1'b0;
            hi_seen <= 1'b0;
            state <= twsi_pkg::TW_HIGH;
          end else if (!master_select && scl_rise) begin
            state <= twsi_pkg::TW_HIGH;
          end
        end
        twsi_pkg::TW_HIGH: begin
          // Another driver may stretch or cut the high phase
          if (scl_s) begin
            hi_seen <= 1'b1;
          end
          if (master_select && sample_now) begin
            scl_drive <= !(sync_format && byte_end);
            state <= twsi_pkg::TW_NEXT;
          end else if (!master_select && scl_fall) begin
            state <= twsi_pkg::TW_NEXT;
          end
        end
        twsi_pkg::TW_NEXT: begin
          // One cycle after the clock falls, so data never moves on the edge, except after a sync master's last bit
          if (!byte_end) begin
            bit_cnt <= bit_cnt + 4'h1;
            sda_drive <= pull_low(shift, bit_cnt + 4'h1);
            state <= twsi_pkg::TW_LOW;
          end else if (master_select && !sync_format && stop_pend) begin
            sda_drive <= 1'b1;
            state <= twsi_pkg::TW_STOP_LOW;
          end else if (can_go || (!master_select && sync_format)) begin
            scl_drive <= master_select;
            shift <= load_val;
            tx_take_p <= take_tx;
            bit_cnt <= twsi_pkg::TWSI_CNT_RST;
            sda_drive <= pull_low(load_val, twsi_pkg::TWSI_CNT_RST);
            state <= twsi_pkg::TW_LOW;
          end else if (sync_format) begin
            scl_drive <= 1'b0;
            sda_drive <= 1'b0;
            state <= twsi_pkg::TW_IDLE;
          end else begin
            scl_drive <= 1'b1;
            sda_drive <= 1'b0;
            state <= twsi_pkg::TW_HOLD;
          end
        end
        twsi_pkg::TW_HOLD: begin
          if (master_select && stop_pend) begin
            sda_drive <= 1'b1;
            state <= twsi_pkg::TW_STOP_LOW;
          end else if (can_go) begin
            scl_drive <= master_select;
            shift <= load_val;
            tx_take_p <= take_tx;
            bit_cnt <= twsi_pkg::TWSI_CNT_RST;
            sda_drive <= pull_low(load_val, twsi_pkg::TWSI_CNT_RST);
            state <= twsi_pkg::TW_LOW;
          end
        end
        twsi_pkg::TW_STOP_LOW: begin
          if (tick) begin
            scl_drive <= 1'b0;
            state <= twsi_pkg::TW_STOP_HIGH;
          end
        end
        twsi_pkg::TW_STOP_HIGH: begin
          // Data rises only once the clock is truly high
          if (scl_s && tick) begin
            sda_drive <= 1'b0;
            stop_take_p <= 1'b1;
            state <= twsi_pkg::TW_IDLE;
          end
        end
        default: begin
          state <= twsi_pkg::TW_IDLE;
        end
      endcase
      // A slave follows conditions made by the master at any point
      if (!master_select && !sync_format && state != twsi_pkg::TW_IDLE) begin
        if (stop_seen) begin
          scl_drive <= 1'b0;
          sda_drive <= 1'b0;
          state <= twsi_pkg::TW_IDLE;
        end else if (start_seen) begin
          scl_drive <= 1'b0;
          sda_drive <= 1'b0;
          bit_cnt <= twsi_pkg::TWSI_CNT_RST;
          state <= twsi_pkg::TW_LOW;
        end
      end
    end
  end

  // Transmit buffer; a write in the cycle it empties is kept
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_buf <= twsi_pkg::TWSI_DATA_RST;
      tx_empty <= 1'b1;
    end else begin
      if (tx_take_p) begin
        tx_empty <= 1'b1;
      end
      if (tx_write && (tx_empty || tx_take_p)) begin
        tx_buf <= tx_data;
        tx_empty <= 1'b0;
      end
    end
  end

  // Status flags; the hardware set wins over a clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      receive_full_flag <= 1'b0;
      overrun_loss_flag <= 1'b0;
    end else begin
      if (rx_read) begin
        receive_full_flag <= 1'b0;
      end
      if (rx_store_p) begin
        receive_full_flag <= 1'b1;
      end
      if (overrun_clear) begin
        overrun_loss_flag <= 1'b0;
      end
      if (rx_over_p) begin
        overrun_loss_flag <= 1'b1;
      end
    end
  end

  // Pending start and stop requests
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_pend <= 1'b0;
      stop_pend <= 1'b0;
    end else begin
      if (start_take_p) begin
        start_pend <= 1'b0;
      end
      if (start_req) begin
        start_pend <= 1'b1;
      end
      if (stop_take_p) begin
        stop_pend <= 1'b0;
      end
      if (stop_req) begin
        stop_pend <= 1'b1;
      end
    end
  end

  // One shared request line for every source
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (transmit_mode && tx_empty) || receive_full_flag || overrun_loss_flag;
    end
  end

  // Open drain: the output level is always low, only the enable moves
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_drive;
  assign sda_oe = sda_drive;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  slave_clock_a: assert property ((!master_select && scl_oe) |-> state == twsi_pkg::TW_HOLD)
    else $error("slave drives clock outside hold");
  start_order_a: assert property (state == twsi_pkg::TW_START |-> sda_oe && !scl_oe)
    else $error("start condition order wrong");
  stop_release_a: assert property (stop_take_p |-> !sda_oe && !scl_oe)
    else $error("stop left a line pulled");
  ack_capture_a: assert property ((sample_now && bit_cnt == twsi_pkg::TWSI_ACK_BIT
    && transmit_mode && !sync_format) |=> ack_received == $past(sda_s))
    else $error("acknowledge not captured");
  high_wait_a: assert property ((state == twsi_pkg::TW_HIGH && master_select && !hi_seen)
    |-> !scl_oe ##1 state == twsi_pkg::TW_HIGH)
    else $error("master left high before seeing it");
  hold_low_a: assert property (state == twsi_pkg::TW_HOLD |-> scl_oe)
    else $error("hold without clock low");
  open_drain_a: assert property ($fell(sda_oe) |-> !sda_out && !scl_out)
    else $error("pin driven high");
  master_clock_a: assert property ((master_select && state == twsi_pkg::TW_LOW) |-> scl_oe)
    else $error("master low phase not driven");
  overrun_set_a: assert property (rx_over_p |=> overrun_loss_flag && receive_full_flag)
    else $error("overrun not flagged");
  tx_accept_a: assert property ((tx_write && tx_empty) |=> !tx_empty && tx_buf == $past(tx_data))
    else $error("transmit write lost");
  ack_drive_a: assert property ((state == twsi_pkg::TW_LOW && bit_cnt == twsi_pkg::TWSI_ACK_BIT
    && !sync_format && !transmit_mode) |-> sda_oe == !ack_level)
    else $error("wrong acknowledge level");
  bit_order_a: assert property ((state == twsi_pkg::TW_LOW && sync_format && transmit_mode)
    |-> sda_oe == !(lsb_first ? shift[0] : shift[7]))
    else $error("wrong bit order");
  irq_join_a: assert property ($rose(overrun_loss_flag) |=> irq)
    else $error("request not on shared line");
  overrun_keep_a: assert property ((overrun_loss_flag && !overrun_clear) |=> overrun_loss_flag)
    else $error("overrun flag dropped");
endmodule // twsi_top

// [tb/twsi_peer.sv]
// Far-side peer: an I2C-format slave that takes bytes from a master, and a
// clock-sync master that sends bytes on request.
// Assumes pulled-up wires that the bench resolves from every pull-low.
`timescale 1ns/100ps
module twsi_peer (
  input wire logic sys_clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_val,
  input wire logic [3:0] stretch,
  output logic scl_low,
  output logic sda_low
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic active = 1'b0;
  logic [7:0] shift = 8'h00;
  int bits = 0;
  int hold = 0;
  int rx_q[$];

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Slave side: start/stop detection, shifting, acknowledge and stretching
  always @(posedge sys_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (hold == 1) begin
      scl_low <= 1'b0;
    end
    if (hold > 0) begin
      hold <= hold - 1;
    end
    if (scl && scl_q && sda_q && !sda) begin
      active <= 1'b1;
      bits <= 0;
    end else if (scl && scl_q && !sda_q && sda) begin
      active <= 1'b0;
    end else if (active && scl && !scl_q) begin
      if (bits < 8) begin
        shift <= {shift[6:0], sda};
      end
      bits <= bits + 1;
    end else if (active && !scl && scl_q) begin
      // A slow slave keeps the clock low a while after every fall
      if (stretch != 4'h0) begin
        scl_low <= 1'b1;
        hold <= stretch;
      end
      if (bits == 8) begin
        sda_low <= !ack_val;
        rx_q.push_back(shift);
      end
      if (bits == 9) begin
        sda_low <= 1'b0;
        bits <= 0;
      end
    end
  end

  // Clock-sync master: idle high, data set while the clock is low, LSB first
  task automatic send_sync(input logic [7:0] value);
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      scl_low = 1'b1;
      repeat (8) @(negedge sys_clk);
      sda_low = !value[i];
      repeat (8) @(negedge sys_clk);
      scl_low = 1'b0;
      repeat (16) @(negedge sys_clk);
    end
    sda_low = 1'b0;
  endtask
endmodule // twsi_peer

// [tb/test_two_wire_serial_interface.sv]
// Self-checking bench of the two-wire serial unit against a behavioural peer.
// Assumes twsi_pkg, twsi_top and twsi_peer are compiled first.
`timescale 1ns/100ps
module test_two_wire_serial_interface;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic master_select = 1'b1;
  logic sync_format = 1'b0;
  logic transmit_mode = 1'b1;
  logic ack_level = 1'b0;
  logic lsb_first = 1'b0;
  logic [3:0] clock_divider_select = 4'h0;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic tx_write = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_read = 1'b0;
  logic overrun_clear = 1'b0;
  logic tx_empty, receive_full_flag, ack_received, overrun_loss_flag, bus_busy, irq;
  logic [7:0] receive_data_reg;
  logic scl_out, scl_oe, sda_out, sda_oe, peer_scl_low, peer_sda_low;
  logic ack_val = 1'b0;
  logic [3:0] stretch = 4'h0;
  wire scl;
  wire sda;
  int seed = 61060;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int sent_q[$];
  logic [7:0] b0, b1;
  logic [7:0] cap = 8'h00;
  int cap_bits = 0;

  // Wires are pulled up and only ever pulled low by either party
  assign scl = !(scl_oe || peer_scl_low);
  assign sda = !(sda_oe || peer_sda_low);

  // Clocks, the link one with its own period and phase
  always #20 sys_clk = !sys_clk;
  initial begin
    #13;
    forever #80 link_clk = !link_clk;
  end

  twsi_top dut (.sys_clk(sys_clk), .reset(reset), .link_clk(link_clk), .master_select(master_select),
    .sync_format(sync_format), .transmit_mode(transmit_mode), .ack_level(ack_level), .lsb_first(lsb_first),
    .clock_divider_select(clock_divider_select), .start_req(start_req), .stop_req(stop_req),
    .tx_write(tx_write), .tx_data(tx_data), .rx_read(rx_read), .overrun_clear(overrun_clear),
    .tx_empty(tx_empty), .receive_full_flag(receive_full_flag), .receive_data_reg(receive_data_reg),
    .ack_received(ack_received), .overrun_loss_flag(overrun_loss_flag), .bus_busy(bus_busy), .irq(irq),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));

  // Clock-sync receiver on the wires: data taken on each rising clock, MSB first
  always @(posedge scl) begin
    if (sync_format && master_select) begin
      cap = {cap[6:0], sda};
      cap_bits++;
    end
  end

  twsi_peer peer (.sys_clk(sys_clk), .scl(scl), .sda(sda), .ack_val(ack_val), .stretch(stretch),
    .scl_low(peer_scl_low), .sda_low(peer_sda_low));

  task automatic step;
    @(negedge sys_clk);
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs under two thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results;
    end
  end

  // Main sequence
  initial begin
    // Long enough for the link domain to see three of its edges in reset
    repeat (16) step;
    reset = 1'b0;
    step;
    chk_bit(tx_empty, 1'b1);
    chk_bit(ack_received, 1'b1);
    chk_bit(receive_full_flag, 1'b0);
    chk_bit(overrun_loss_flag, 1'b0);
    chk_bit(scl_oe, 1'b0);
    chk_bit(sda_oe, 1'b0);
    chk_byte(receive_data_reg, twsi_pkg::TWSI_DATA_RST);
    // Master writes of two bytes, plain then with a slow slave
    for (int r = 0; r < 2; r++) begin
      stretch = (r == 1) ? 4'h6 : 4'h0;
      ack_val = 1'b0;
      clock_divider_select = ($random(seed) & 1) ? 4'h1 : 4'h0;
      sent_q.push_back($random(seed) & 8'hff);
      sent_q.push_back($random(seed) & 8'hff);
      tx_data = 8'(sent_q[0]);
      tx_write = 1'b1;
      start_req = 1'b1;
      step;
      tx_write = 1'b0;
      start_req = 1'b0;
      chk_bit(tx_empty, 1'b0);
      while (peer.rx_q.size() < 1) step;
      // No next byte yet: the clock must stay held low
      repeat (40) step;
      chk_bit(scl, 1'b0);
      chk_bit(scl_oe, 1'b1);
      chk_bit(ack_received, 1'b0);
      chk_bit(bus_busy, 1'b1);
      chk_bit(irq, 1'b1);
      tx_data = 8'(sent_q[1]);
      tx_write = 1'b1;
      ack_val = 1'b1;
      step;
      tx_write = 1'b0;
      while (tx_empty !== 1'b1) step;
      stop_req = 1'b1;
      step;
      stop_req = 1'b0;
      while (peer.rx_q.size() < 2) step;
      while (bus_busy !== 1'b0) step;
      repeat (4) step;
      for (int i = 0; i < 2; i++) begin
        chk_byte(peer.rx_q[i], sent_q[i]);
      end
      chk_bit(ack_received, 1'b1);
      chk_bit(scl, 1'b1);
      chk_bit(sda, 1'b1);
      peer.rx_q.delete();
      sent_q.delete();
    end
    // Clock-sync slave receive, LSB first, then an overrun
    master_select = 1'b0;
    sync_format = 1'b1;
    transmit_mode = 1'b0;
    lsb_first = 1'b1;
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    repeat (4) step;
    peer.send_sync(b0);
    repeat (10) step;
    chk_bit(receive_full_flag, 1'b1);
    chk_byte(receive_data_reg, b0);
    peer.send_sync(b1);
    repeat (10) step;
    chk_bit(overrun_loss_flag, 1'b1);
    chk_byte(receive_data_reg, b0);
    rx_read = 1'b1;
    step;
    rx_read = 1'b0;
    repeat (2) step;
    chk_bit(receive_full_flag, 1'b0);
    chk_bit(overrun_loss_flag, 1'b1);
    chk_bit(irq, 1'b1);
    overrun_clear = 1'b1;
    step;
    overrun_clear = 1'b0;
    repeat (2) step;
    chk_bit(overrun_loss_flag, 1'b0);
    chk_bit(irq, 1'b0);
    // Clock-sync master send, MSB first; the clock stops high after the byte
    master_select = 1'b1;
    transmit_mode = 1'b1;
    lsb_first = 1'b0;
    cap_bits = 0;
    b0 = 8'($random(seed));
    tx_data = b0;
    tx_write = 1'b1;
    step;
    tx_write = 1'b0;
    while (cap_bits < 8) step;
    repeat (40) step;
    chk_byte(cap, b0);
    chk_bit(cap_bits == 8, 1'b1);
    chk_bit(scl, 1'b1);
    chk_bit(scl_out, 1'b0);
    chk_bit(sda_out, 1'b0);
    results;
  end
endmodule // test_two_wire_serial_interface
